// [csr_pkg.sv]
// Package with the data-memory map, status bit layout and carrier types of the core registers.
package csr_pkg;

  // Data address width: one sector bit above an eight-bit location.
  localparam int DADDR_W = 9;

  // Register indices inside the special area; each sits at byte address four times its index.
  localparam logic [7:0] IDX_PORT_A      = 8'h00;
  localparam logic [7:0] IDX_PTR_SECTOR0 = 8'h01;
  localparam logic [7:0] IDX_PORT_B      = 8'h02;
  localparam logic [7:0] IDX_PTR_B_LOW   = 8'h03;
  localparam logic [7:0] IDX_PTR_B_SEC   = 8'h04;
  localparam logic [7:0] IDX_ACC         = 8'h05;
  localparam logic [7:0] IDX_PC_LOW      = 8'h06;
  localparam logic [7:0] IDX_TBL_PTR_LOW = 8'h07;
  localparam logic [7:0] IDX_TBL_LATCH   = 8'h08;
  localparam logic [7:0] IDX_TBL_PTR_HI  = 8'h09;
  localparam logic [7:0] IDX_STATUS      = 8'h0a;
  localparam logic [7:0] IDX_PORT_C      = 8'h0c;
  localparam logic [7:0] IDX_PTR_C_LOW   = 8'h0d;
  localparam logic [7:0] IDX_PTR_C_SEC   = 8'h0e;

  // Status bit positions.
  localparam int BIT_CARRY = 0;
  localparam int BIT_HALF  = 1;
  localparam int BIT_ZERO  = 2;
  localparam int BIT_WRAP  = 3;
  localparam int BIT_SLEEP = 4;
  localparam int BIT_WDOG  = 5;
  localparam int BIT_NIL   = 6;
  localparam int BIT_LESS  = 7;

  // Reset values.
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // Operation classes reported by the execution pipeline.
  typedef enum logic [2:0] {
    ALU_NONE  = 3'b000,
    ALU_ADD   = 3'b001,
    ALU_SUB   = 3'b010,
    ALU_LOGIC = 3'b011,
    ALU_ROTC  = 3'b100
  } csr_alu_kind_e;

  // Bus slave states.
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } csr_bus_state_e;

  // One ALU step as issued by the pipeline.
  typedef struct packed {
    logic          valid;
    csr_alu_kind_e kind;
    logic [7:0]    op_a;
    logic [7:0]    op_b;
    logic          carry_in;
    logic [7:0]    result;
    logic          rot_carry;
    logic          to_acc;
  } csr_alu_s;

  // System events that touch the power-down and time-out flags.
  typedef struct packed {
    logic sleep_op;
    logic watchdog_refresh_op;
    logic watchdog_expired;
  } csr_sys_s;

  // True for the three locations that have no storage of their own.
  function automatic logic csr_is_port(input logic [7:0] loc);
    csr_is_port = (loc == IDX_PORT_A) || (loc == IDX_PORT_B) || (loc == IDX_PORT_C);
  endfunction

endpackage

// [csr_core.sv]
// Core special registers: indirect ports, pointers, accumulator, program-counter low byte,
// table registers, status flags and the general data memory, behind an Avalon-MM slave.
//
// Operation
// - Indirect port accesses go to the location held by that port's pointer.
// - First indirect port with its single pointer reaches sector 0 only.
// - Second and third ports take sector from pointer high byte, location from low.
// - An indirect access resolving onto a port location itself does nothing.
// - Five pointer bytes are real registers, readable and writable like any other.
// - Writing the counter low byte jumps within the current page, upper bits kept.
// - A write to the counter low byte adds one dummy cycle for refetch.
// - Table reads fetch the program word addressed by both table pointers.
// - Table read latches the upper byte, hands the lower byte to the destination.
// - Status is eight bits; software writes never change sleep or watchdog flags.
// - Carry set on add carry or subtract no-borrow; rotates through carry update it.
// - Half flag set on low nibble carry, or no nibble borrow in subtraction.
// - Zero flag follows whether the result is zero.
// - Wrap flag set when carry into and out of the top bit differ.
// - Sleep flag cleared by power-up and refresh, set by sleep entry only.
// - Watchdog flag cleared by power-up, refresh or sleep; set on expiry.
// - Signed-less flag equals wrap flag XOR result top bit.
// - Calls and interrupts never save status; only return address is stacked.
// - ALU results reach the accumulator; no direct register-to-register moves.
// - Extended direct addresses are nine bits: sector above, location below.
// - Unused special locations read as zero.
// - General memory at 80H to FFH per sector; special registers at 00H to 7FH.
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps

module csr_core
  import csr_pkg::*;
#(
  parameter int PROG_W   = 16,
  parameter int GP_WORDS = 256
)(
  input  wire logic              mclk,              // System clock, 100 MHz.
  input  wire logic              rst,               // Asynchronous reset, active high.
  input  wire logic [10:0]       avs_address,       // Byte address, data address in [10:2].
  input  wire logic              avs_read,          // Read request.
  input  wire logic              avs_write,         // Write request.
  input  wire logic [31:0]       avs_writedata,     // Write data, low byte used.
  input  wire logic [3:0]        avs_byteenable,    // Byte lanes, lane 0 carries data.
  output logic [31:0]            avs_readdata,      // Read data, upper bits zero.
  output logic                   avs_waitrequest,   // Low for the answering cycle.
  input  wire csr_alu_s          alu_req,           // ALU step from the pipeline.
  input  wire csr_sys_s          sys_evt,           // Sleep, refresh and expiry events.
  input  wire logic [7:0]        pc_now_low,        // Current program counter low byte.
  input  wire logic              tbl_read,          // Table read strobe with fetched word.
  input  wire logic [PROG_W-1:0] prog_word,         // Program word at the table address.
  output logic [15:0]            tbl_addr,          // Table address to program memory.
  output logic [7:0]             tbl_low_byte,      // Lower byte of the last table word.
  output logic                   tbl_done,          // Pulse: table word taken.
  output logic                   pc_jump,           // Pulse: load the counter low byte.
  output logic [7:0]             pc_target_low,     // New counter low byte.
  output logic                   pc_dummy_cycle,    // Pulse: stall the pipeline one cycle.
  output logic [7:0]             acc_out,           // Accumulator contents.
  output logic [7:0]             status_out         // Status register contents.
);

  localparam int GP_AW = $clog2(GP_WORDS);

  csr_bus_state_e              state_reg;
  logic                        waitrequest_reg;
  logic [31:0]                 readdata_reg;
  logic [7:0]                  pointer_sector0_reg;
  logic [7:0]                  pointer_b_low_reg;
  logic [7:0]                  pointer_b_sector_reg;
  logic [7:0]                  pointer_c_low_reg;
  logic [7:0]                  pointer_c_sector_reg;
  logic [7:0]                  acc_reg;
  logic [7:0]                  table_pointer_low_reg;
  logic [7:0]                  table_pointer_high_reg;
  logic [7:0]                  table_high_byte_latch_reg;
  logic [7:0]                  tbl_low_reg;
  logic                        tbl_done_reg;
  logic                        pc_jump_reg;
  logic [7:0]                  pc_target_reg;
  logic                        pc_dummy_reg;
  logic [7:0]                  status_reg;
  logic [7:0]                  status_next;
  logic [7:0]                  gp_mem [GP_WORDS];
  logic [DADDR_W-1:0]          req_addr;
  logic [DADDR_W-1:0]          tgt;
  logic                        tgt_null;
  logic [7:0]                  rd_val;
  logic                        wr_fire;
  logic                        wr_sfr;
  logic                        wr_gp;
  logic [7:0]                  wdata;
  logic [7:0]                  b_eff;
  logic [8:0]                  sum9;
  logic [4:0]                  lo5;
  logic [7:0]                  low7;
  logic [7:0]                  alu_res;
  logic                        wrap_new;

  // The bus carries one data-memory location per word; the nine-bit data address sits above
  // the two byte-offset bits, so extended direct addresses reach both sectors.
  assign req_addr = avs_address[10:2];
  assign wdata    = avs_writedata[7:0];

  // Resolve indirect ports onto the location named by their pointers.
  always_comb
  begin
    case (req_addr[7:0])
      IDX_PORT_A: tgt = {1'b0, pointer_sector0_reg};
      IDX_PORT_B: tgt = {pointer_b_sector_reg[0], pointer_b_low_reg};
      IDX_PORT_C: tgt = {pointer_c_sector_reg[0], pointer_c_low_reg};
      default:    tgt = req_addr;
    endcase
    // A direct address is never a port after resolution, so this only catches pointer loops.
    tgt_null = csr_is_port(tgt[7:0]);
  end

  // Read value of the resolved location; general memory from 80H up, registers below.
  always_comb
  begin
    rd_val = 8'h00;
    if (!tgt_null)
    begin
      if (tgt[7])
      begin
        rd_val = gp_mem[GP_AW'({tgt[8], tgt[6:0]})];
      end
      else
      begin
        case (tgt[7:0])
          IDX_PTR_SECTOR0: rd_val = pointer_sector0_reg;
          IDX_PTR_B_LOW:   rd_val = pointer_b_low_reg;
          IDX_PTR_B_SEC:   rd_val = pointer_b_sector_reg;
          IDX_PTR_C_LOW:   rd_val = pointer_c_low_reg;
          IDX_PTR_C_SEC:   rd_val = pointer_c_sector_reg;
          IDX_ACC:         rd_val = acc_reg;
          IDX_PC_LOW:      rd_val = pc_now_low;
          IDX_TBL_PTR_LOW: rd_val = table_pointer_low_reg;
          IDX_TBL_PTR_HI:  rd_val = table_pointer_high_reg;
          IDX_TBL_LATCH:   rd_val = table_high_byte_latch_reg;
          IDX_STATUS:      rd_val = status_reg;
          default:         rd_val = 8'h00;
        endcase
      end
    end
  end

  // A write lands at the edge where the master sees waitrequest low; lane 0 must be enabled.
  // Each bus access moves one byte between one location and the master, which is why no
  // register-to-register transfer exists here: moves pass through the accumulator.
  assign wr_fire = (state_reg == BUS_ACK) && avs_write && avs_byteenable[0];
  assign wr_sfr  = wr_fire && !tgt_null && !tgt[7];
  assign wr_gp   = wr_fire && !tgt_null && tgt[7];

  // Bus slave: one idle cycle takes the request, the next cycle answers with waitrequest low.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg       <= BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg    <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            state_reg       <= BUS_ACK;
            waitrequest_reg <= 1'b0;
            readdata_reg    <= avs_read ? {24'h00_0000, rd_val} : 32'h0000_0000;
          end
        end
        BUS_ACK:
        begin
          state_reg       <= BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
        default:
        begin
          state_reg       <= BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
      endcase
    end
  end

  // Memory pointers behave as ordinary registers; increments are read-modify-write passes.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pointer_sector0_reg  <= RST_BYTE;
      pointer_b_low_reg    <= RST_BYTE;
      pointer_b_sector_reg <= RST_BYTE;
      pointer_c_low_reg    <= RST_BYTE;
      pointer_c_sector_reg <= RST_BYTE;
    end
    else if (wr_sfr)
    begin
      case (tgt[7:0])
        IDX_PTR_SECTOR0: pointer_sector0_reg  <= wdata;
        IDX_PTR_B_LOW:   pointer_b_low_reg    <= wdata;
        IDX_PTR_B_SEC:   pointer_b_sector_reg <= wdata;
        IDX_PTR_C_LOW:   pointer_c_low_reg    <= wdata;
        IDX_PTR_C_SEC:   pointer_c_sector_reg <= wdata;
        default:         pointer_sector0_reg  <= pointer_sector0_reg;
      endcase
    end
  end

  // Accumulator: an ALU result bound for it wins over a same-cycle bus write.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      acc_reg <= RST_BYTE;
    end
    else if (alu_req.valid && alu_req.to_acc && (alu_req.kind != ALU_NONE))
    begin
      acc_reg <= alu_res;
    end
    else if (wr_sfr && (tgt[7:0] == IDX_ACC))
    begin
      acc_reg <= wdata;
    end
  end

  // Counter low byte: a write requests an in-page jump and a one-cycle refetch stall.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pc_jump_reg   <= 1'b0;
      pc_target_reg <= RST_BYTE;
      pc_dummy_reg  <= 1'b0;
    end
    else
    begin
      pc_jump_reg  <= wr_sfr && (tgt[7:0] == IDX_PC_LOW);
      pc_dummy_reg <= wr_sfr && (tgt[7:0] == IDX_PC_LOW);
      if (wr_sfr && (tgt[7:0] == IDX_PC_LOW))
      begin
        pc_target_reg <= wdata;
      end
    end
  end

  // Table pointers are written by software; a table read latches both halves of the word.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      table_pointer_low_reg     <= RST_BYTE;
      table_pointer_high_reg    <= RST_BYTE;
      table_high_byte_latch_reg <= RST_BYTE;
      tbl_low_reg               <= RST_BYTE;
      tbl_done_reg              <= 1'b0;
    end
    else
    begin
      tbl_done_reg <= tbl_read;
      if (wr_sfr && (tgt[7:0] == IDX_TBL_PTR_LOW))
      begin
        table_pointer_low_reg <= wdata;
      end
      if (wr_sfr && (tgt[7:0] == IDX_TBL_PTR_HI))
      begin
        table_pointer_high_reg <= wdata;
      end
      if (tbl_read)
      begin
        table_high_byte_latch_reg <= prog_word[PROG_W-1 -: 8];
        tbl_low_reg               <= prog_word[7:0];
      end
    end
  end

  // Adder shared by add and subtract; subtraction adds the inverted operand, so the carry
  // out is the no-borrow indication and the pipeline supplies carry_in as one for a plain sub.
  always_comb
  begin
    b_eff   = (alu_req.kind == ALU_SUB) ? ~alu_req.op_b : alu_req.op_b;
    sum9    = {1'b0, alu_req.op_a} + {1'b0, b_eff} + {8'h00, alu_req.carry_in};
    lo5     = {1'b0, alu_req.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_req.carry_in};
    low7    = {1'b0, alu_req.op_a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, alu_req.carry_in};
    wrap_new = low7[7] ^ sum9[8];
    if ((alu_req.kind == ALU_ADD) || (alu_req.kind == ALU_SUB))
    begin
      alu_res = sum9[7:0];
    end
    else
    begin
      alu_res = alu_req.result;
    end
  end

  // Next status: software write first, then result flags, then system events on top.
  // Calls and interrupt entry have no path here, so the flags are never stacked or restored.
  always_comb
  begin
    status_next = status_reg;
    if (wr_sfr && (tgt[7:0] == IDX_STATUS))
    begin
      status_next[3:0] = wdata[3:0];
    end
    if (alu_req.valid)
    begin
      case (alu_req.kind)
        ALU_ADD, ALU_SUB:
        begin
          status_next[BIT_CARRY] = sum9[8];
          status_next[BIT_HALF]  = lo5[4];
          status_next[BIT_ZERO]  = (sum9[7:0] == 8'h00);
          status_next[BIT_WRAP]  = wrap_new;
          status_next[BIT_LESS]  = wrap_new ^ sum9[7];
          status_next[BIT_NIL]   = (sum9[7:0] == 8'h00);
        end
        ALU_LOGIC:
        begin
          status_next[BIT_ZERO] = (alu_req.result == 8'h00);
          status_next[BIT_LESS] = status_next[BIT_WRAP] ^ alu_req.result[7];
        end
        ALU_ROTC:
        begin
          status_next[BIT_CARRY] = alu_req.rot_carry;
        end
        default:
        begin
          status_next[BIT_CARRY] = status_next[BIT_CARRY];
        end
      endcase
    end
    if (sys_evt.watchdog_refresh_op)
    begin
      status_next[BIT_SLEEP] = 1'b0;
      status_next[BIT_WDOG]  = 1'b0;
    end
    if (sys_evt.sleep_op)
    begin
      status_next[BIT_SLEEP] = 1'b1;
      status_next[BIT_WDOG]  = 1'b0;
    end
    // Expiry is a hardware set, so it wins over a clear in the same cycle.
    if (sys_evt.watchdog_expired)
    begin
      status_next[BIT_WDOG] = 1'b1;
    end
  end

  // Status register; power-up clears every flag including sleep and watchdog.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      status_reg <= RST_STATUS;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // General data memory, two sectors of 128 bytes; contents are not reset.
  always_ff @(posedge mclk)
  begin
    if (wr_gp)
    begin
      gp_mem[GP_AW'({tgt[8], tgt[6:0]})] <= wdata;
    end
  end

  // Outputs straight from flip-flops.
  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign tbl_addr        = {table_pointer_high_reg, table_pointer_low_reg};
  assign tbl_low_byte    = tbl_low_reg;
  assign tbl_done        = tbl_done_reg;
  assign pc_jump         = pc_jump_reg;
  assign pc_target_low   = pc_target_reg;
  assign pc_dummy_cycle  = pc_dummy_reg;
  assign acc_out         = acc_reg;
  assign status_out      = status_reg;

endmodule

// [csr_core_sva.sv]
// Concurrent checks on the ports of the core special registers.
`timescale 1ns/100ps

module csr_core_sva
  import csr_pkg::*;
#(
  parameter int PROG_W = 16
)(
  input wire logic              mclk,            // Clock.
  input wire logic              rst,             // Reset.
  input wire logic [10:0]       avs_address,     // Byte address.
  input wire logic              avs_read,        // Read request.
  input wire logic              avs_write,       // Write request.
  input wire logic [31:0]       avs_writedata,   // Write data.
  input wire logic [3:0]        avs_byteenable,  // Byte lanes.
  input wire logic              avs_waitrequest, // Wait.
  input wire csr_alu_s          alu_req,         // ALU step.
  input wire csr_sys_s          sys_evt,         // System events.
  input wire logic              tbl_read,        // Table strobe.
  input wire logic [PROG_W-1:0] prog_word,       // Program word.
  input wire logic [7:0]        tbl_low_byte,    // Table low byte.
  input wire logic              tbl_done,        // Table pulse.
  input wire logic              pc_jump,         // Jump pulse.
  input wire logic [7:0]        pc_target_low,   // Jump target.
  input wire logic              pc_dummy_cycle,  // Stall pulse.
  input wire logic [7:0]        acc_out,         // Accumulator.
  input wire logic [7:0]        status_out       // Status.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Reference sum of an addition step and the accepted counter-low write.
  logic [8:0] add_sum;
  logic       pc_wr;
  assign add_sum = {1'b0, alu_req.op_a} + {1'b0, alu_req.op_b} + 9'(alu_req.carry_in);
  assign pc_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
                 && (avs_address[9:2] == IDX_PC_LOW);

  property p_wait_once;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("request not answered");
  property p_wait_short;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("answer too long");
  property p_pc_jump;
    pc_wr |=> pc_jump && (pc_target_low == $past(avs_writedata[7:0]));
  endproperty
  a_pc_jump: assert property (p_pc_jump) else $error("no jump on counter write");
  property p_pc_dummy;
    pc_wr |=> pc_dummy_cycle ##1 !pc_dummy_cycle;
  endproperty
  a_pc_dummy: assert property (p_pc_dummy) else $error("dummy cycle wrong");
  property p_tbl;
    tbl_read |=> tbl_done && (tbl_low_byte == $past(prog_word[7:0]));
  endproperty
  a_tbl: assert property (p_tbl) else $error("table low byte wrong");
  property p_carry;
    alu_req.valid && (alu_req.kind == ALU_ADD) |=>
      (status_out[BIT_CARRY] == $past(add_sum[8]))
      && (status_out[BIT_ZERO] == ($past(add_sum[7:0]) == 8'h00));
  endproperty
  a_carry: assert property (p_carry) else $error("carry or zero wrong");
  property p_less;
    alu_req.valid && (alu_req.kind inside {ALU_ADD, ALU_SUB}) |=>
      status_out[BIT_LESS] == (status_out[BIT_WRAP] ^ $past(alu_req.result[7]));
  endproperty
  a_less: assert property (p_less) else $error("signed less wrong");
  property p_sleep;
    sys_evt.sleep_op && !sys_evt.watchdog_expired |=> status_out[5:4] == 2'b01;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  property p_expire;
    sys_evt.watchdog_expired |=> status_out[BIT_WDOG];
  endproperty
  a_expire: assert property (p_expire) else $error("expiry not flagged");
  property p_sys_only;
    $changed(status_out[5:4]) |-> ($past(sys_evt) != '0);
  endproperty
  a_sys_only: assert property (p_sys_only) else $error("system flag moved");
endmodule

// [tb_csr_core.sv]
// Self-checking testbench for the core special registers.
`timescale 1ns/100ps

module tb_csr_core
  import csr_pkg::*;
;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest, tbl_read;
  logic        tbl_done, pc_jump, pc_dummy_cycle;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [7:0]  pc_now_low, tbl_low_byte, pc_target_low, acc_out, status_out, rd;
  logic [15:0] prog_word, tbl_addr;
  csr_alu_s    alu_req;
  csr_sys_s    sys_evt;
  int          num_errors, cmp_count, cycles;

  csr_core #(.PROG_W(16), .GP_WORDS(256)) dut (.mclk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .alu_req, .sys_evt, .pc_now_low, .tbl_read, .prog_word, .tbl_addr, .tbl_low_byte,
    .tbl_done, .pc_jump, .pc_target_low, .pc_dummy_cycle, .acc_out, .status_out);

  // Clock of 10 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cuts a hung run short.
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= {a, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= ~w;
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [8:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    chk(rd, exp, what);
  endtask

  task automatic t_indirect;
    wr(9'h190, 8'h77);
    wr(9'h0a0, 8'h19);
    wr(9'h085, 8'h21);
    wr(9'h001, 8'h90);
    wr(9'h000, 8'h3c);
    rdc(9'h090, 8'h3c, "port a target");
    rdc(9'h190, 8'h77, "port a sector");
    rdc(9'h001, 8'h90, "pointer a");
    wr(9'h004, 8'h01);
    wr(9'h003, 8'h85);
    wr(9'h002, 8'h5e);
    rdc(9'h185, 8'h5e, "port b target");
    rdc(9'h085, 8'h21, "port b other sector");
    rdc(9'h004, 8'h01, "pointer b sector");
    wr(9'h00e, 8'h03);
    wr(9'h00d, 8'ha0);
    wr(9'h00c, 8'h6b);
    rdc(9'h1a0, 8'h6b, "port c odd sector");
    wr(9'h00e, 8'h02);
    rdc(9'h00c, 8'h19, "port c even sector");
    wr(9'h001, 8'h0c);
    wr(9'h000, 8'h99);
    rdc(9'h000, 8'h00, "port onto port");
    rdc(9'h00c, 8'h19, "port untouched");
    $display("test indirect done");
  endtask

  task automatic t_map;
    wr(9'h0f0, 8'h55);
    wr(9'h1f0, 8'haa);
    rdc(9'h0f0, 8'h55, "sector 0 memory");
    rdc(9'h1f0, 8'haa, "sector 1 memory");
    wr(9'h00f, 8'h5a);
    rdc(9'h00f, 8'h00, "unused special");
    rdc(9'h00b, 8'h00, "unused 0b");
    wr(9'h005, 8'h3a);
    rdc(9'h005, 8'h3a, "accumulator");
    // A write with lane 0 disabled is answered but must leave the register alone.
    avs_byteenable <= 4'he;
    wr(9'h005, 8'h11);
    avs_byteenable <= 4'hf;
    rdc(9'h005, 8'h3a, "lane 0 off");
    $display("test map done");
  endtask

  task automatic t_pc;
    rdc(9'h006, 8'h4d, "counter low read");
    wr(9'h006, 8'hc3);
    @(posedge mclk);
    chk({7'h00, pc_jump}, 8'h01, "jump pulse");
    chk({7'h00, pc_dummy_cycle}, 8'h01, "dummy pulse");
    chk(pc_target_low, 8'hc3, "jump target");
    @(posedge mclk);
    chk({7'h00, pc_dummy_cycle}, 8'h00, "single dummy");
    $display("test counter done");
  endtask

  task automatic t_table;
    wr(9'h007, 8'h34);
    wr(9'h009, 8'h12);
    @(posedge mclk);
    chk(tbl_addr[7:0], 8'h34, "table addr low");
    chk(tbl_addr[15:8], 8'h12, "table addr high");
    prog_word <= 16'hbe5a;
    tbl_read <= 1'b1;
    @(posedge mclk);
    tbl_read <= 1'b0;
    @(posedge mclk);
    chk(tbl_low_byte, 8'h5a, "table low");
    chk({7'h00, tbl_done}, 8'h01, "table done");
    rdc(9'h008, 8'hbe, "table latch");
    wr(9'h008, 8'h00);
    rdc(9'h008, 8'hbe, "latch read only");
    $display("test table done");
  endtask

  task automatic t_alu;
    csr_alu_kind_e k[8] = '{ALU_ADD, ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_LOGIC,
                            ALU_ROTC, ALU_ROTC};
    logic [7:0] a[8] = '{8'h7f, 8'hff, 8'h80, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00};
    logic [7:0] b[8] = '{8'h01, 8'h01, 8'hff, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00};
    logic [7:0] r[8] = '{8'h80, 8'h00, 8'h7f, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00};
    logic [7:0] e[8] = '{8'h0a, 8'h47, 8'h89, 8'h47, 8'h80, 8'h04, 8'h05, 8'h04};
    logic       c[8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic       ro[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    wr(9'h00a, 8'hff);
    rdc(9'h00a, 8'h0f, "status write");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      alu_req <= '{1'b1, k[i], a[i], b[i], c[i], r[i], ro[i], 1'b1};
      @(posedge mclk);
      alu_req <= '0;
      @(posedge mclk);
      chk(status_out, e[i], "alu flags");
      chk(acc_out, r[i], "alu to acc");
    end
    // A status write and an addition land on the same edge; the result flags must win.
    fork
      wr(9'h00a, 8'h00);
      begin
        repeat (2) @(posedge mclk);
        alu_req <= '{1'b1, ALU_ADD, 8'h7f, 8'h01, 1'b0, 8'h80, 1'b0, 1'b0};
        @(posedge mclk);
        alu_req <= '0;
      end
    join
    @(posedge mclk);
    chk(status_out, 8'h0a, "alu beats status write");
    $display("test alu done");
  endtask

  task automatic t_events;
    csr_sys_s   ev[5] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b100};
    logic [1:0] x[5] = '{2'b01, 2'b11, 2'b00, 2'b10, 2'b01};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      sys_evt <= ev[i];
      @(posedge mclk);
      sys_evt <= '0;
      @(posedge mclk);
      chk({6'h00, status_out[5:4]}, {6'h00, x[i]}, "system flags");
    end
    wr(9'h00a, 8'h20);
    rdc(9'h00a, 8'h10, "system flags kept");
    $display("test events done");
  endtask

  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial
  begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 11'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    alu_req = '0;
    sys_evt = '0;
    tbl_read = 1'b0;
    prog_word = 16'h0000;
    pc_now_low = 8'h4d;
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(status_out, RST_STATUS, "status reset");
    chk(acc_out, RST_BYTE, "acc reset");
    $display("test reset done");
    t_indirect();
    t_map();
    t_pc();
    t_table();
    t_alu();
    t_events();
    stop_test();
  end
endmodule

bind csr_core csr_core_sva #(.PROG_W(PROG_W)) u_sva (.mclk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .alu_req, .sys_evt,
  .tbl_read, .prog_word, .tbl_low_byte, .tbl_done, .pc_jump, .pc_target_low,
  .pc_dummy_cycle, .acc_out, .status_out);
